// File: inc/psc_defines.vh
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Register indices; byte address is four times the index
`define PSC_IDX_LEGACY 8'h00
`define PSC_IDX_STATUS 8'h12
`define PSC_ADDR_LEGACY 8'h00
`define PSC_ADDR_STATUS 8'h48
`define PSC_ADDR_SUBCMD 8'h50
`define PSC_ADDR_CONFIG 8'h54
`define PSC_ADDR_INT_STAT 8'h58
`define PSC_ADDR_INT_CLR 8'h5C
`define PSC_ADDR_INT_EN 8'h60

// Status word fields
`define PSC_ST_ALERT 13
`define PSC_ST_FAULT 12
`define PSC_ST_SEC_HI 11
`define PSC_ST_SEC_LO 10
`define PSC_ST_SWITCH 8
`define PSC_ST_RESET 7
`define PSC_ST_EDIT 5
`define PSC_ST_PIN 4

// Security state codes
`define PSC_SEC_INIT 2'h0
`define PSC_SEC_UNLOCKED 2'h1
`define PSC_SEC_UNUSED 2'h2
`define PSC_SEC_LOCKED 2'h3

// Legacy readback signature
`define PSC_SIGNATURE 16'hFFA5

// Subcommand addresses
`define PSC_CMD_ENTER_EDIT 16'h0090
`define PSC_CMD_EXIT_EDIT 16'h0092
`define PSC_CMD_SWITCH_TOGGLE 16'h0022
`define PSC_CMD_LOCK 16'h0030
`define PSC_CMD_UNLOCK 16'h0031

// Config register layout and reset
`define PSC_CFG_SWITCH_BIT 16
`define PSC_CFG_RESET 17'h1FFFF

// Interrupt event bits
`define PSC_EV_ALERT 0
`define PSC_EV_FAULT 1
`define PSC_EV_EDIT 2
`define PSC_EV_REJECT 3

// AXI responses
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2

`endif

// File: verilog/psc_regs.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.vh"

module psc_regs (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [7:0] alert_vec,
  input wire [7:0] fault_vec,
  output reg alert_pin_out,
  output reg alert_pin_oe,
  output reg autonomous_switch_flag,
  output reg config_edit_flag,
  output reg [1:0] security_state_field,
  output reg irq
);

  reg [7:0] aw_addr;
  reg aw_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_full;
  reg [16:0] cfg;
  reg reset_flag;
  reg legacy_armed;
  reg [15:0] last_cmd;
  reg [15:0] cmd_code;
  reg cmd_pend;
  reg [3:0] int_stat;
  reg [3:0] int_en;
  reg alert_d;
  reg fault_d;

  wire [31:0] wmask;
  wire wr_go;
  wire rd_go;
  wire locked;
  wire alert_summary_flag;
  wire fault_summary_flag;
  wire wr_legacy;
  wire wr_subcmd;
  wire wr_cfg;
  wire wr_ok;
  wire cfg_allowed;
  wire restricted;
  wire [15:0] status_word;
  wire [3:0] events;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb[gi]}};
    end
  endgenerate

  assign wr_go = aw_full & w_full & ~bvalid;
  assign rd_go = arvalid & arready;
  assign locked = (security_state_field == `PSC_SEC_LOCKED);
  assign alert_summary_flag = |(alert_vec & cfg[7:0]);
  assign fault_summary_flag = |(fault_vec & cfg[15:8]);
  // Config writes need edit mode and an unlocked part
  assign cfg_allowed = config_edit_flag & ~locked;
  assign wr_legacy = wr_go & (aw_addr == `PSC_ADDR_LEGACY);
  assign wr_subcmd = wr_go & ((aw_addr == `PSC_ADDR_LEGACY) | (aw_addr == `PSC_ADDR_SUBCMD));
  assign wr_cfg = wr_go & (aw_addr == `PSC_ADDR_CONFIG) & cfg_allowed;
  assign wr_ok = (aw_addr == `PSC_ADDR_LEGACY) | (aw_addr == `PSC_ADDR_SUBCMD)
    | ((aw_addr == `PSC_ADDR_CONFIG) & cfg_allowed)
    | (aw_addr == `PSC_ADDR_INT_CLR) | (aw_addr == `PSC_ADDR_INT_EN);
  // Only unlock and lock stay usable while locked
  assign restricted = (cmd_code != `PSC_CMD_UNLOCK) & (cmd_code != `PSC_CMD_LOCK);

  // Reserved bits tied to zero; bits 3:0 belong to other blocks
  assign status_word = {2'b00, alert_summary_flag, fault_summary_flag, security_state_field, 1'b0,
    autonomous_switch_flag, reset_flag, 1'b0, config_edit_flag, alert_pin_oe, 4'h0};

  assign events[`PSC_EV_ALERT] = alert_summary_flag & ~alert_d;
  assign events[`PSC_EV_FAULT] = fault_summary_flag & ~fault_d;
  assign events[`PSC_EV_EDIT] = cmd_pend & (cmd_code == `PSC_CMD_ENTER_EDIT) & ~locked & ~config_edit_flag;
  assign events[`PSC_EV_REJECT] = cmd_pend & locked & restricted;

  // Write address and data channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 8'h00;
      aw_full <= 1'b0;
      awready <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_full <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PSC_RESP_OKAY;
    end else if (ce) begin
      if (!aw_full && !bvalid) begin
        awready <= 1'b1;
      end
      if (!w_full && !bvalid) begin
        wready <= 1'b1;
      end
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read in flight, answered the cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PSC_RESP_OKAY;
    end else if (ce) begin
      if (!rvalid && !rd_go) begin
        arready <= 1'b1;
      end
      if (rd_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `PSC_RESP_OKAY;
        case (araddr)
          `PSC_ADDR_LEGACY: begin
            rdata <= {16'h0000, legacy_armed ? `PSC_SIGNATURE : last_cmd};
          end
          `PSC_ADDR_STATUS: begin
            rdata <= {16'h0000, status_word};
          end
          `PSC_ADDR_SUBCMD: begin
            rdata <= {16'h0000, last_cmd};
          end
          `PSC_ADDR_CONFIG: begin
            if (locked) begin
              rdata <= 32'h0000_0000;
              rresp <= `PSC_RESP_SLVERR;
            end else begin
              rdata <= {15'h0000, cfg};
            end
          end
          `PSC_ADDR_INT_STAT: begin
            rdata <= {28'h0000000, int_stat};
          end
          `PSC_ADDR_INT_EN: begin
            rdata <= {28'h0000000, int_en};
          end
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `PSC_RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Signature is armed by a legacy write and spent by the next access of any kind
  always @(posedge aclk) begin
    if (!aresetn) begin
      legacy_armed <= 1'b0;
    end else if (ce) begin
      if (wr_legacy) begin
        legacy_armed <= 1'b1;
      end else if (wr_go || rd_go) begin
        legacy_armed <= 1'b0;
      end
    end
  end

  // Subcommand intake and processing, one cycle after the write
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_cmd <= 16'h0000;
      cmd_code <= 16'h0000;
      cmd_pend <= 1'b0;
      cfg <= `PSC_CFG_RESET;
      security_state_field <= `PSC_SEC_INIT;
      config_edit_flag <= 1'b0;
      autonomous_switch_flag <= 1'b0;
      reset_flag <= 1'b1;
    end else if (ce) begin
      if (security_state_field == `PSC_SEC_INIT) begin
        security_state_field <= `PSC_SEC_UNLOCKED;
      end
      if (wr_cfg) begin
        cfg <= (cfg & ~wmask[16:0]) | (w_data[16:0] & wmask[16:0]);
      end
      cmd_pend <= 1'b0;
      if (cmd_pend && !(locked && restricted)) begin
        case (cmd_code)
          `PSC_CMD_ENTER_EDIT: begin
            config_edit_flag <= 1'b1;
          end
          `PSC_CMD_EXIT_EDIT: begin
            if (config_edit_flag) begin
              config_edit_flag <= 1'b0;
              autonomous_switch_flag <= cfg[`PSC_CFG_SWITCH_BIT];
              reset_flag <= 1'b0;
            end
          end
          `PSC_CMD_SWITCH_TOGGLE: begin
            autonomous_switch_flag <= ~autonomous_switch_flag;
          end
          `PSC_CMD_LOCK: begin
            security_state_field <= `PSC_SEC_LOCKED;
          end
          `PSC_CMD_UNLOCK: begin
            security_state_field <= `PSC_SEC_UNLOCKED;
          end
          default: begin
            cmd_pend <= 1'b0;
          end
        endcase
      end
      if (wr_subcmd) begin
        last_cmd <= w_data[15:0] & wmask[15:0];
        cmd_code <= w_data[15:0] & wmask[15:0];
        cmd_pend <= 1'b1;
      end
    end
  end

  // Alert pin, interrupt bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      alert_pin_out <= 1'b0;
      alert_pin_oe <= 1'b0;
      alert_d <= 1'b0;
      fault_d <= 1'b0;
      int_stat <= 4'h0;
      int_en <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      // Open drain: only ever drives low
      alert_pin_out <= 1'b0;
      alert_pin_oe <= alert_summary_flag | fault_summary_flag;
      alert_d <= alert_summary_flag;
      fault_d <= fault_summary_flag;
      if (wr_go && aw_addr == `PSC_ADDR_INT_EN) begin
        int_en <= w_data[3:0] & wmask[3:0];
      end
      // New events win over a clear in the same cycle
      if (wr_go && aw_addr == `PSC_ADDR_INT_CLR) begin
        int_stat <= (int_stat & ~(w_data[3:0] & wmask[3:0])) | events;
      end else begin
        int_stat <= int_stat | events;
      end
      irq <= |(int_stat & int_en);
    end
  end

endmodule

`default_nettype wire

// File: dv/psc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.vh"
module psc_regs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic [7:0] alert_vec,
  input wire logic [7:0] fault_vec,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe,
  input wire logic autonomous_switch_flag,
  input wire logic config_edit_flag,
  input wire logic [1:0] security_state_field
);
  logic [7:0] ra;
  wire st_rd = ra == `PSC_ADDR_STATUS;
  // Address of the read in flight, so a response can be tied to its register
  always_ff @(posedge aclk) begin
    if (arvalid && arready) ra <= araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready) else $error("late read");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("late write");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("resp dropped");
  sec_code_a: assert property (security_state_field != `PSC_SEC_UNUSED) else $error("bad code");
  sec_boot_a: assert property ($rose(aresetn) |=> security_state_field == `PSC_SEC_UNLOCKED) else $error("boot");
  // Frozen cycles carry no new pin value, so only check after an enabled edge
  pin_follow_a: assert property ($past(ce) |->
    !alert_pin_out && alert_pin_oe == $past(|{alert_vec, fault_vec})) else $error("pin");
  live_bits_a: assert property ($rose(rvalid) && st_rd && !rresp |-> rdata[13] == $past(|alert_vec)
    && rdata[12] == $past(|fault_vec) && rdata[4] == $past(alert_pin_oe)) else $error("live bits");
  mode_bits_a: assert property ($rose(rvalid) && st_rd && !rresp |-> rdata[8] == $past(autonomous_switch_flag)
    && rdata[11:10] == $past(security_state_field) && rdata[5] == $past(config_edit_flag)) else $error("mode bits");
  rsvd_bits_a: assert property ($rose(rvalid) && st_rd |-> rdata[31:14] == 0 && !rdata[9] && !rdata[6])
    else $error("reserved");
  edit_late_a: assert property ($rose(config_edit_flag) |-> bvalid || $past(bvalid)) else $error("edit early");
  cover property ($rose(config_edit_flag));
  cover property ($rose(security_state_field[1]));
  cover property ($rose(alert_pin_oe));
endmodule
bind psc_regs psc_regs_props chk (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .alert_vec, .fault_vec, .alert_pin_out, .alert_pin_oe,
  .autonomous_switch_flag, .config_edit_flag, .security_state_field);
`default_nettype wire

// File: dv/psc_host.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  // One access at a time; a wait that runs out raises hung
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 1'b0;
    // Blocking so the caller sees it at once
    if (n == 64) hung = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 64) hung = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [15:0] e;} psc_row_t;
  localparam logic [1:0] ok = `PSC_RESP_OKAY;
  localparam logic [1:0] se = `PSC_RESP_SLVERR;
  localparam logic [7:0] lg = `PSC_ADDR_LEGACY;
  localparam logic [7:0] st = `PSC_ADDR_STATUS;
  int fail_count = 0;
  int tests_run = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] alert_vec = 8'h00;
  logic [7:0] fault_vec = 8'h00;
  logic [31:0] d;
  logic [1:0] r;
  psc_row_t rows [22];
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp, security_state_field;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hung;
  wire alert_pin_out, alert_pin_oe, autonomous_switch_flag, config_edit_flag, irq;
  always #5 aclk = ~aclk;
  psc_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hung);
  psc_regs dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .alert_vec, .fault_vec,
    .alert_pin_out, .alert_pin_oe, .autonomous_switch_flag, .config_edit_flag, .security_state_field, .irq);
  task automatic conclude;
    $display("tests %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic op(input psc_row_t x);
    if (x.w) host.wr(x.a, x.d, r);
    else host.rd(x.a, d, r);
    `CHK(r, x.r)
    if (!x.w) `CHK(d, {16'h0000, x.e})
    if (hung) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic irq_is(input logic v);
    int n;
    for (n = 0; n < 8 && irq !== v; n++) @(posedge aclk);
    `CHK(irq, v)
  endtask
  initial begin
    rows = '{'{1'b0, st, 32'h0, ok, 16'h0480},
      '{1'b1, `PSC_ADDR_CONFIG, 32'h0FFFF, se, 16'h0},
      '{1'b1, lg, 32'h0090, ok, 16'h0},
      '{1'b0, lg, 32'h0, ok, 16'hFFA5},
      '{1'b0, lg, 32'h0, ok, 16'h0090},
      '{1'b0, st, 32'h0, ok, 16'h04A0},
      '{1'b1, `PSC_ADDR_CONFIG, 32'h1FFFF, ok, 16'h0},
      '{1'b1, `PSC_ADDR_SUBCMD, 32'h0092, ok, 16'h0},
      '{1'b0, st, 32'h0, ok, 16'h0500},
      '{1'b1, lg, 32'h0022, ok, 16'h0},
      '{1'b0, st, 32'h0, ok, 16'h0400},
      '{1'b0, lg, 32'h0, ok, 16'h0022},
      '{1'b1, lg, 32'h0030, ok, 16'h0},
      '{1'b0, st, 32'h0, ok, 16'h0C00},
      '{1'b0, `PSC_ADDR_CONFIG, 32'h0, se, 16'h0},
      '{1'b1, lg, 32'h0022, ok, 16'h0},
      '{1'b0, st, 32'h0, ok, 16'h0C00},
      '{1'b0, `PSC_ADDR_INT_STAT, 32'h0, ok, 16'h000C},
      '{1'b1, lg, 32'h0031, ok, 16'h0},
      '{1'b1, st, 32'hFFFF, se, 16'h0},
      '{1'b0, st, 32'h0, ok, 16'h0400},
      '{1'b0, 8'h70, 32'h0, se, 16'h0}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      op(rows[i]);
      $display("row %0d done", i);
    end
    op('{1'b1, `PSC_ADDR_INT_EN, 32'h3, ok, 16'h0});
    alert_vec <= 8'h01;
    irq_is(1'b1);
    op('{1'b0, st, 32'h0, ok, 16'h2410});
    op('{1'b1, `PSC_ADDR_INT_CLR, 32'h1, ok, 16'h0});
    irq_is(1'b0);
    fault_vec <= 8'h80;
    irq_is(1'b1);
    op('{1'b0, st, 32'h0, ok, 16'h3410});
    op('{1'b1, `PSC_ADDR_INT_EN, 32'h0, ok, 16'h0});
    irq_is(1'b0);
    op('{1'b0, `PSC_ADDR_INT_STAT, 32'h0, ok, 16'h000E});
    $display("interrupt test done");
    // Vectors fall while frozen: the pin must hold until the enable returns
    ce <= 1'b0;
    alert_vec <= 8'h00;
    fault_vec <= 8'h00;
    repeat (3) @(posedge aclk);
    `CHK(alert_pin_oe, 1'b1)
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(alert_pin_oe, 1'b0)
    $display("clock enable test done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    op('{1'b0, st, 32'h0, ok, 16'h0480});
    $display("second reset test done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
